// ---- inc/unb_pkg.sv ----
package unb_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] UNB_OFF_CTRL = 8'h00;
    localparam logic [7:0] UNB_OFF_BUF = 8'h04;
    localparam logic [7:0] UNB_OFF_BAUD = 8'h08;
    localparam logic [7:0] UNB_OFF_T2RL = 8'h0C;

    // serial_control field positions
    localparam int CTL_MSEL_HI = 7;
    localparam int CTL_MSEL_LO = 6;
    localparam int CTL_MPE = 5;
    localparam int CTL_REN = 4;
    localparam int CTL_TX9 = 3;
    localparam int CTL_RX9 = 2;
    localparam int CTL_TXDONE = 1;
    localparam int CTL_RXDONE = 0;

    // baud control field positions
    localparam int BD_DOUBLE = 0;
    localparam int BD_TXSEL = 1;
    localparam int BD_RXSEL = 2;
    localparam int BD_W = 3;

    // reset values
    localparam logic [7:0] UNB_CTRL_RST = 8'h00;
    localparam logic [2:0] UNB_BAUD_RST = 3'h0;
    localparam logic [15:0] UNB_T2RL_RST = 16'h0000;
    localparam logic [7:0] UNB_BUF_RST = 8'h00;

    // rate figures: shift mode bit = clk/12, fixed mode sample = clk/4 (x16 = clk/64)
    localparam int UNB_M0_DIV = 12;
    localparam int UNB_M0_HALF = 6;
    localparam int UNB_M2_DIV = 4;
    localparam logic [3:0] UNB_OVS_LAST = 4'hF;
    localparam logic [3:0] UNB_SAMPLE_PH = 4'h7;

    // bits following the start bit (shift mode has no start bit)
    localparam logic [3:0] UNB_LEN_9BIT = 4'hA;
    localparam logic [3:0] UNB_LEN_8BIT = 4'h9;
    localparam logic [3:0] UNB_LEN_SHIFT = 4'h8;

    typedef enum logic [1:0] {
        UNB_M_SHIFT = 2'b00,
        UNB_M_8BIT = 2'b01,
        UNB_M_9FIX = 2'b10,
        UNB_M_9VAR = 2'b11
    } unb_mode_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_WAIT = 2'b01,
        TX_SHIFT = 2'b11
    } unb_tx_st_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_BITS = 2'b11
    } unb_rx_st_t;

endpackage

// ---- rtl/unb_uart.sv ----
`timescale 1ns/1ns
// Overview of operation
// - mode bits hi=1, lo=0 select fixed-rate 9-bit asynchronous mode
// - fixed 9-bit mode runs at clk/64, or clk/32 with baud_double
// - 9-bit frame: start 0, eight data, ninth bit, stop 1
// - transmit loads buffer byte lsb first, ninth bit in ninth position
// - start bit waits for the next bit-rate tick
// - tx_done_flag sets when the stop bit starts driving the line
// - receive lsb first; byte to buffer, ninth bit stored, rx_done_flag set
// - accept only if rx_done clear and (shift mode, no multiproc or stop bit one)
// - both mode bits one: 9-bit mode with timer-derived rate
// - any buffer write starts a transmission in every mode
// - shift mode receives on enable, rx_done clear and transmitter idle; async on start bit
// - shift mode bit rate is clk/12
// - variable modes use timer 1 or timer 2 overflows, per direction
// - timer 1 rate: overflow rate times 2^baud_double over 32
// - timer 1 autoreload rate follows from its overflow spacing
// - timer 2: one serial bit per 16 overflows
// - timer 2 as baud generator counts every two clocks
// - clock-select bits put timer 2 in baud-generator use
// - tx and rx may run at different rates from different timers
// - timer 2 rate is clk/(32*(65536-reload))
// - buffer write loads transmit side, read returns separate receive byte
// - async receiver takes a falling rx edge as a possible start
module unb_uart
    import unb_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic t1_ovf,
    input wire logic rxd_i,
    output logic rxd_o,
    output logic rxd_oe_n,
    output logic txd_o
);

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        return a == ADDR_W'(off);
    endfunction

    // per-direction x16 tick: fixed mode divider, else timer 2 or timer 1
    function automatic logic pick_tick(input logic fixed, input logic use_t2,
                                       input logic m2t, input logic t1t, input logic t2t);
        return fixed ? m2t : (use_t2 ? t2t : t1t);
    endfunction

    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [BD_W-1:0] baud_r;
    logic [15:0] t2_rl_r;
    logic [7:0] rx_buf_r;
    logic [31:0] hrdata_r;
    logic wr_pend_r;
    logic [ADDR_W-1:0] wr_addr_r;

    // ---------------- bus slave ----------------
    wire bus_req = hsel & htrans[1] & hready;
    wire wr_ctrl = wr_pend_r & reg_hit(wr_addr_r, UNB_OFF_CTRL);
    wire wr_buf = wr_pend_r & reg_hit(wr_addr_r, UNB_OFF_BUF);
    wire wr_baud = wr_pend_r & reg_hit(wr_addr_r, UNB_OFF_BAUD);
    wire wr_t2rl = wr_pend_r & reg_hit(wr_addr_r, UNB_OFF_T2RL);

    // read data is picked in the address phase so it can leave a flip-flop
    wire [31:0] rd_mux = reg_hit(haddr, UNB_OFF_CTRL) ? {24'h000000, ctrl_r} :
                         reg_hit(haddr, UNB_OFF_BUF) ? {24'h000000, rx_buf_r} :
                         reg_hit(haddr, UNB_OFF_BAUD) ? {29'h00000000, baud_r} :
                         reg_hit(haddr, UNB_OFF_T2RL) ? {16'h0000, t2_rl_r} : 32'h00000000;

    assign hreadyout = 1'b1; // zero wait states
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    // address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
            hrdata_r <= 32'h00000000;
        end else begin
            wr_pend_r <= bus_req & hwrite;
            if (bus_req) begin
                wr_addr_r <= haddr;
            end
            if (bus_req & ~hwrite) begin
                hrdata_r <= rd_mux;
            end
        end
    end

    // mode and control fields
    wire [1:0] mode_bits = {ctrl_r[CTL_MSEL_HI], ctrl_r[CTL_MSEL_LO]};
    unb_mode_t mode;
    assign mode = unb_mode_t'(mode_bits);
    wire mode_shift = (mode == UNB_M_SHIFT);
    wire mode_fixed = (mode == UNB_M_9FIX);
    wire mode_nine = mode_bits[1]; // mode 3 shares mode 2 framing
    wire multiproc_enable = ctrl_r[CTL_MPE];
    wire rx_enable = ctrl_r[CTL_REN];
    wire tx_ninth_bit = ctrl_r[CTL_TX9];
    wire rx_done_flag = ctrl_r[CTL_RXDONE];
    wire baud_double = baud_r[BD_DOUBLE];
    wire tx_clock_select = baud_r[BD_TXSEL];
    wire rx_clock_select = baud_r[BD_RXSEL];

    // ---------------- rate generation ----------------
    logic [3:0] m0_cnt_r;
    logic [1:0] m2_cnt_r;
    logic t1_half_r;
    logic t2_pre_r;
    logic [15:0] t2_cnt_r;

    wire m0_tick = (m0_cnt_r == 4'(UNB_M0_DIV - 1));
    wire m2_tick = baud_double ? m2_cnt_r[0] : (m2_cnt_r == 2'(UNB_M2_DIV - 1));
    wire t1_tick = t1_ovf & (baud_double | t1_half_r);
    wire t2_run = tx_clock_select | rx_clock_select;
    wire t2_inc = t2_run & t2_pre_r;
    wire t2_ovf = t2_inc & (&t2_cnt_r);
    // each direction picks its own source, so rates may differ
    wire tx_stick = pick_tick(mode_fixed, tx_clock_select, m2_tick, t1_tick, t2_ovf);
    wire rx_stick = pick_tick(mode_fixed, rx_clock_select, m2_tick, t1_tick, t2_ovf);

    // dividers; timer 1 overflows halve unless doubled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            m0_cnt_r <= 4'h0;
            m2_cnt_r <= 2'h0;
            t1_half_r <= 1'b0;
        end else begin
            m0_cnt_r <= m0_tick ? 4'h0 : m0_cnt_r + 4'h1;
            m2_cnt_r <= m2_cnt_r + 2'h1;
            if (t1_ovf) begin
                t1_half_r <= ~t1_half_r;
            end
        end
    end

    // timer 2 in baud-generator use: count every other clock, reload on overflow
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            t2_pre_r <= 1'b0;
            t2_cnt_r <= UNB_T2RL_RST;
        end else if (!t2_run) begin
            t2_pre_r <= 1'b0;
            t2_cnt_r <= t2_rl_r; // primed so the first period is full length
        end else begin
            t2_pre_r <= ~t2_pre_r;
            if (t2_ovf) begin
                t2_cnt_r <= t2_rl_r;
            end else if (t2_inc) begin
                t2_cnt_r <= t2_cnt_r + 16'h0001;
            end
        end
    end

    // ---------------- transmitter ----------------
    unb_tx_st_t tx_st_r;
    logic [9:0] tx_sh_r;
    logic [3:0] tx_left_r;
    logic [3:0] tx_ph_r;
    logic sout_r;
    logic tx_m0_r;

    // sixteen sample ticks make one bit in the async modes
    wire tx_bit = mode_shift ? m0_tick : (tx_stick & (tx_ph_r == UNB_OVS_LAST));
    wire [3:0] tx_len = mode_shift ? UNB_LEN_SHIFT : (mode_nine ? UNB_LEN_9BIT : UNB_LEN_8BIT);
    wire tx_ninth_val = mode_nine ? tx_ninth_bit : 1'b1;
    wire tx_end = (tx_st_r == TX_SHIFT) & tx_bit & (tx_left_r == 4'h0);
    wire tx_stop_out = (tx_st_r == TX_SHIFT) & tx_bit & (tx_left_r == 4'h1) & ~mode_shift;
    // async: flag when stop goes out; shift mode: at the end of the eighth bit
    wire tx_done_set = tx_stop_out | (tx_end & mode_shift);

    // phase counter runs freely so a new frame lines up with the next bit tick
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_ph_r <= 4'h0;
        end else if (tx_stick) begin
            tx_ph_r <= tx_ph_r + 4'h1;
        end
    end

    // a write mid-frame restarts the frame with the new byte
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_st_r <= TX_IDLE;
            tx_sh_r <= 10'h3FF;
            tx_left_r <= 4'h0;
            sout_r <= 1'b1;
            tx_m0_r <= 1'b0;
        end else if (wr_buf) begin
            tx_sh_r <= {1'b1, tx_ninth_val, hwdata[7:0]};
            tx_left_r <= tx_len;
            tx_st_r <= TX_WAIT;
            sout_r <= 1'b1;
            tx_m0_r <= 1'b0;
        end else begin
            case (tx_st_r)
                TX_IDLE: begin
                    sout_r <= 1'b1;
                end
                TX_WAIT: begin
                    if (tx_bit) begin
                        tx_st_r <= TX_SHIFT;
                        if (mode_shift) begin
                            sout_r <= tx_sh_r[0];
                            tx_sh_r <= {1'b1, tx_sh_r[9:1]};
                            tx_left_r <= tx_left_r - 4'h1;
                            tx_m0_r <= 1'b1;
                        end else begin
                            sout_r <= 1'b0; // start bit
                        end
                    end
                end
                TX_SHIFT: begin
                    if (tx_end) begin
                        tx_st_r <= TX_IDLE;
                        sout_r <= 1'b1;
                        tx_m0_r <= 1'b0;
                    end else if (tx_bit) begin
                        sout_r <= tx_sh_r[0];
                        tx_sh_r <= {1'b1, tx_sh_r[9:1]};
                        tx_left_r <= tx_left_r - 4'h1;
                    end
                end
                default: begin
                    tx_st_r <= TX_IDLE;
                end
            endcase
        end
    end

    // ---------------- receiver ----------------
    logic rx_s1_r;
    logic rx_s2_r;
    logic rx_s3_r;
    unb_rx_st_t rx_st_r;
    logic [9:0] rx_sh_r;
    logic [3:0] rx_left_r;
    logic [3:0] rx_ph_r;

    // pin synchroniser; the second stage feeds sampling, the second and third stages feed the edge detect
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
            rx_s3_r <= 1'b1;
        end else begin
            rx_s1_r <= rxd_i;
            rx_s2_r <= rx_s1_r;
            rx_s3_r <= rx_s2_r;
        end
    end

    wire rx_fall = rx_s3_r & ~rx_s2_r;
    wire rx_async_go = ~mode_shift & rx_enable & rx_fall;
    // shift mode shares the data pin, so it waits for the transmitter
    wire rx_sync_go = mode_shift & rx_enable & ~rx_done_flag & (tx_st_r == TX_IDLE);
    wire rx_samp = mode_shift ? m0_tick : (rx_stick & (rx_ph_r == UNB_SAMPLE_PH));
    wire [9:0] rx_sh_nxt = {rx_s2_r, rx_sh_r[9:1]}; // lsb arrives first
    wire rx_last = (rx_st_r == RX_BITS) & rx_samp & (rx_left_r == 4'h1);
    wire rx_stop = rx_sh_nxt[9];
    wire rx_accept = rx_last & ~rx_done_flag & (mode_shift | ~multiproc_enable | rx_stop);
    wire [7:0] rx_byte = mode_shift ? rx_sh_nxt[9:2] : (mode_nine ? rx_sh_nxt[7:0] : rx_sh_nxt[8:1]);
    wire rx_ninth_val = mode_nine ? rx_sh_nxt[8] : rx_stop;
    wire [3:0] rx_len = mode_nine ? UNB_LEN_9BIT : UNB_LEN_8BIT;
    wire rx_m0_busy = mode_shift & (rx_st_r == RX_BITS);

    // receive frame sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_st_r <= RX_IDLE;
            rx_sh_r <= 10'h000;
            rx_left_r <= 4'h0;
            rx_ph_r <= 4'h0;
        end else begin
            rx_ph_r <= (rx_st_r == RX_IDLE) ? 4'h0 : (rx_stick ? rx_ph_r + 4'h1 : rx_ph_r);
            case (rx_st_r)
                RX_IDLE: begin
                    if (rx_sync_go) begin
                        rx_st_r <= RX_BITS;
                        rx_left_r <= UNB_LEN_SHIFT;
                    end else if (rx_async_go) begin
                        rx_st_r <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_samp) begin
                        // a high mid-start is noise, not a frame
                        rx_st_r <= rx_s2_r ? RX_IDLE : RX_BITS;
                        rx_left_r <= rx_len;
                    end
                end
                RX_BITS: begin
                    if (rx_samp) begin
                        rx_sh_r <= rx_sh_nxt;
                        rx_left_r <= rx_left_r - 4'h1;
                        if (rx_last) begin
                            rx_st_r <= RX_IDLE;
                        end
                    end
                end
                default: begin
                    rx_st_r <= RX_IDLE;
                end
            endcase
        end
    end

    // receive buffer holds until the next accepted frame
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_buf_r <= UNB_BUF_RST;
        end else if (rx_accept) begin
            rx_buf_r <= rx_byte;
        end
    end

    // ---------------- control registers ----------------
    // hardware set beats a same-cycle software clear of either flag
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            ctrl_nxt = hwdata[7:0]; // software clears done flags
        end
        if (rx_accept) begin
            ctrl_nxt[CTL_RX9] = rx_ninth_val;
            ctrl_nxt[CTL_RXDONE] = 1'b1;
        end
        if (tx_done_set) begin
            ctrl_nxt[CTL_TXDONE] = 1'b1;
        end
    end

    // register storage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= UNB_CTRL_RST;
            baud_r <= UNB_BAUD_RST;
            t2_rl_r <= UNB_T2RL_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
            if (wr_baud) begin
                baud_r <= hwdata[BD_W-1:0];
            end
            if (wr_t2rl) begin
                t2_rl_r <= hwdata[15:0];
            end
        end
    end

    // ---------------- pins ----------------
    logic m0clk_r;
    logic oe_n_r;

    // shift clock is low for the first half of each bit while a shift-mode transfer runs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            m0clk_r <= 1'b1;
            oe_n_r <= 1'b1;
        end else begin
            m0clk_r <= ~((tx_m0_r | rx_m0_busy) & (m0_cnt_r < 4'(UNB_M0_HALF)));
            oe_n_r <= ~(mode_shift & (tx_st_r == TX_SHIFT) & ~tx_end);
        end
    end

    // async data leaves on txd; shift mode puts data on rxd and the clock on txd
    assign txd_o = mode_shift ? m0clk_r : sout_r;
    assign rxd_o = sout_r;
    assign rxd_oe_n = oe_n_r;

endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %0t got %h expected %h", $time, g, e); end end
// bench: bus master tasks, remote node on the serial pins, timer 1 overflow strobe
module tb_top
    import unb_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic t1_ovf = 1'b0;
    logic [1:0] t1_div = 2'h0;
    logic [21:0] in_bit = 22'd64;
    logic [21:0] out_bit = 22'd64;
    wire logic hreadyout, hresp, rxd_o, rxd_oe_n, txd_o, p_tx, got_stop;
    wire logic [31:0] hrdata;
    wire logic [8:0] got_data;
    // the shared data pin: the block wins while it enables its driver, else the remote
    wire logic rxd_line = rxd_oe_n ? p_tx : rxd_o;
    int got_cnt;
    time stop_t;
    int num_errors = 0;
    int checked = 0;
    // shift-mode data out, taken at each rising shift clock while the block drives the data pin
    logic [7:0] sh_cap = 8'h00;
    always @(posedge txd_o) begin
        if (!rxd_oe_n) begin
            sh_cap <= {rxd_o, sh_cap[7:1]};
        end
    end

    always #4 hclk = ~hclk;

    // timer 1 stand-in: a bare overflow strobe every third clock, no interrupt path
    always @(posedge hclk) begin
        t1_div <= (t1_div == 2'h2) ? 2'h0 : t1_div + 2'h1;
        t1_ovf <= (t1_div == 2'h0);
    end

    unb_uart #(.ADDR_W(8)) unb_uart_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .t1_ovf(t1_ovf), .rxd_i(rxd_line),
        .rxd_o(rxd_o), .rxd_oe_n(rxd_oe_n), .txd_o(txd_o));
    unb_remote unb_remote_inst (.clk(hclk), .line_in(txd_o), .in_bit(in_bit), .out_bit(out_bit),
        .line_out(p_tx), .got_data(got_data), .got_stop(got_stop), .got_cnt(got_cnt), .stop_t(stop_t));

    // one single transfer; hready is the slave's own, so wait on it at each phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? d : 32'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        `CHK(hresp, 1'b0)
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        `CHK(q, e)
    endtask

    // polls a control flag, giving up after lim reads
    task automatic wait_bit(input int b, input int lim);
        logic [31:0] q;
        int n;
        n = 0;
        do begin
            bus(1'b0, UNB_OFF_CTRL, 32'h0, q);
            n++;
        end while (q[b] !== 1'b1 && n < lim);
        `CHK(q[b], 1'b1)
    endtask

    task automatic wait_rx(input int n);
        for (int i = 0; i < 3000 && got_cnt != n; i++) @(posedge hclk);
        `CHK(got_cnt, n)
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk(UNB_OFF_CTRL, 32'(UNB_CTRL_RST));
        rd_chk(UNB_OFF_BAUD, 32'(UNB_BAUD_RST));
        rd_chk(UNB_OFF_T2RL, 32'(UNB_T2RL_RST));
        wr(8'h10, 32'hFFFF_FFFF);
        rd_chk(8'h10, 32'h0);
        $display("test reset values done");
        // fixed rate: plain then doubled, ninth bit one then zero, done flag at stop start
        for (int k = 0; k < 2; k++) begin
            in_bit = k ? 22'd32 : 22'd64;
            wr(UNB_OFF_BAUD, 32'(k));
            wr(UNB_OFF_CTRL, k ? 32'h80 : 32'h88);
            wr(UNB_OFF_BUF, k ? 32'hA3 : 32'h55);
            wait_bit(CTL_TXDONE, 500);
            `CHK($time >= stop_t && $time <= stop_t + 64, 1'b1)
            wait_rx(k + 1);
            `CHK(got_data, k ? 9'h0A3 : 9'h155)
            `CHK(got_stop, 1'b1)
            rd_chk(UNB_OFF_BUF, 32'h0);
        end
        $display("test fixed-rate transmit done");
        // receive, refusal while the flag stands, then multiprocessor filtering on the stop bit
        wr(UNB_OFF_BAUD, 32'h0);
        wr(UNB_OFF_CTRL, 32'h90);
        unb_remote_inst.send(9'h1C6, 1'b1);
        wait_bit(CTL_RXDONE, 50);
        rd_chk(UNB_OFF_BUF, 32'hC6);
        rd_chk(UNB_OFF_CTRL, 32'h95);
        unb_remote_inst.send(9'h011, 1'b1);
        rd_chk(UNB_OFF_BUF, 32'hC6);
        wr(UNB_OFF_CTRL, 32'hB0);
        unb_remote_inst.send(9'h122, 1'b0);
        rd_chk(UNB_OFF_CTRL, 32'hB0);
        unb_remote_inst.send(9'h133, 1'b1);
        rd_chk(UNB_OFF_BUF, 32'h33);
        rd_chk(UNB_OFF_CTRL, 32'hB5);
        $display("test fixed-rate receive done");
        // variable rate: each direction on its own timer, both at once, then swapped
        wr(UNB_OFF_T2RL, 32'hFFFE);
        for (int k = 0; k < 2; k++) begin
            wr(UNB_OFF_BAUD, k ? 32'h5 : 32'h2);
            wr(UNB_OFF_CTRL, 32'hD0);
            in_bit = k ? 22'd48 : 22'd64;
            out_bit = k ? 22'd64 : 22'd96;
            fork
                wr(UNB_OFF_BUF, 32'h3C + k);
                unb_remote_inst.send(9'h0E7 - k, 1'b1);
            join
            wait_rx(3 + k);
            `CHK(got_data, 9'h03C + k)
            rd_chk(UNB_OFF_BUF, 32'hE7 - k);
            rd_chk(UNB_OFF_CTRL, 32'hD3);
        end
        $display("test variable-rate done");
        // 8-bit mode on timer 1: one stop bit after the byte, and that stop bit lands in the ninth-bit field
        wr(UNB_OFF_BAUD, 32'h0);
        wr(UNB_OFF_CTRL, 32'h50);
        in_bit = 22'd96;
        out_bit = 22'd96;
        fork
            wr(UNB_OFF_BUF, 32'h5A);
            unb_remote_inst.send(9'h1A5, 1'b1);
        join
        wait_rx(5);
        `CHK(got_data, 9'h15A)
        rd_chk(UNB_OFF_BUF, 32'hA5);
        rd_chk(UNB_OFF_CTRL, 32'h57);
        $display("test 8-bit mode done");
        // shift mode: a byte out on the data pin, then one clocked in from the idle-high line
        wr(UNB_OFF_CTRL, 32'h00);
        wr(UNB_OFF_BUF, 32'h96);
        wait_bit(CTL_TXDONE, 100);
        `CHK(sh_cap, 8'h96)
        wr(UNB_OFF_CTRL, 32'h10);
        wait_bit(CTL_RXDONE, 100);
        rd_chk(UNB_OFF_BUF, 32'hFF);
        $display("test shift mode done");
        complete_run();
    end

    // watchdog: the sequence needs roughly 7k cycles
    initial begin
        #(8 * 40000);
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        complete_run();
    end
endmodule

// ---- testbench/unb_remote.sv ----
`timescale 1ns/1ns
// remote node: decodes frames on its input, sends frames on an output that idles high
module unb_remote (
    input wire logic clk,
    input wire logic line_in,
    input wire logic [21:0] in_bit,
    input wire logic [21:0] out_bit,
    output logic line_out,
    output logic [8:0] got_data,
    output logic got_stop,
    output int got_cnt,
    output time stop_t
);
    initial begin
        line_out = 1'b1;
        got_cnt = 0;
    end

    // a falling line opens a frame; a start bit gone high again at mid-bit is dropped
    always begin
        @(negedge line_in);
        stop_t = $time + time'(in_bit) * 80;
        repeat (in_bit / 2) @(posedge clk);
        if (!line_in) begin
            for (int i = 0; i < 9; i++) begin
                repeat (in_bit) @(posedge clk);
                got_data[i] = line_in;
            end
            repeat (in_bit) @(posedge clk);
            got_stop = line_in;
            got_cnt++;
        end
    end

    // start, nine bits lsb first, stop value of the caller's choosing, then idle high
    task automatic send(input logic [8:0] d, input logic stop);
        logic [10:0] fr;
        fr = {stop, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge clk);
            line_out <= fr[i];
            repeat (out_bit - 1) @(posedge clk);
        end
        @(posedge clk);
        line_out <= 1'b1;
    endtask
endmodule

// ---- testbench/unb_uart_props.sv ----
`timescale 1ns/1ns
// shadows mode, baud and reload fields from bus writes and times the tx line against them
module unb_uart_chk
    import unb_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic t1_ovf,
    input wire logic rxd_oe_n,
    input wire logic txd_o
);
    logic wv_r;
    logic [ADDR_W-1:0] ad_r;
    logic [1:0] mode_r;
    logic [2:0] bd_r;
    logic [15:0] rl_r;
    logic [21:0] low_r;
    logic [21:0] ovf_r;
    logic [9:0] fr_r;
    wire logic buf_wr = wv_r && ad_r == ADDR_W'(UNB_OFF_BUF);
    wire logic [21:0] t2_bit = 22'd32 * (22'h10000 - 22'(rl_r));

    // shadows land at the end of the data phase, the same edge as the block's registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wv_r <= 1'b0;
            ad_r <= '0;
            mode_r <= 2'h0;
            bd_r <= 3'h0;
            rl_r <= 16'h0000;
            low_r <= '0;
            ovf_r <= '0;
            fr_r <= '0;
        end else begin
            wv_r <= hsel && htrans[1] && hready && hwrite;
            ad_r <= haddr;
            if (wv_r && ad_r == ADDR_W'(UNB_OFF_CTRL)) mode_r <= hwdata[7:6];
            if (wv_r && ad_r == ADDR_W'(UNB_OFF_BAUD)) bd_r <= hwdata[2:0];
            if (wv_r && ad_r == ADDR_W'(UNB_OFF_T2RL)) rl_r <= hwdata[15:0];
            low_r <= txd_o ? '0 : low_r + 22'h1;
            ovf_r <= txd_o ? '0 : ovf_r + 22'(t1_ovf);
            // frame timer only for doubled fixed-rate frames started from idle
            if (fr_r != '0) fr_r <= (fr_r == 10'd352) ? '0 : fr_r + 10'd1;
            else if ($fell(txd_o) && mode_r == UNB_M_9FIX && bd_r[BD_DOUBLE]) fr_r <= 10'd1;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    reset_idle_a: assert property ($rose(hresetn) |-> txd_o && rxd_oe_n)
        else $error("serial pins not idle after reset");
    fix_bit_a: assert property ($rose(txd_o) && mode_r == UNB_M_9FIX
        |-> low_r != '0 && low_r % (bd_r[BD_DOUBLE] ? 32 : 64) == 0)
        else $error("fixed-rate bit time wrong");
    t1_bit_a: assert property ($rose(txd_o) && mode_r == UNB_M_9VAR && !bd_r[BD_TXSEL]
        |-> ovf_r != '0 && ovf_r % (bd_r[BD_DOUBLE] ? 16 : 32) == 0)
        else $error("timer 1 bit time wrong");
    t2_bit_a: assert property ($rose(txd_o) && mode_r == UNB_M_9VAR && bd_r[BD_TXSEL]
        |-> low_r != '0 && low_r % t2_bit == 0)
        else $error("timer 2 bit time wrong");
    shift_clk_a: assert property ($rose(txd_o) && mode_r == UNB_M_SHIFT |-> low_r == UNB_M0_HALF)
        else $error("shift clock low phase wrong");
    async_pin_a: assert property (mode_r != UNB_M_SHIFT && $past(mode_r) != UNB_M_SHIFT |-> rxd_oe_n)
        else $error("data pin driven outside shift mode");
    tx_start_a: assert property (buf_wr && mode_r == UNB_M_9FIX && !bd_r[BD_DOUBLE] && txd_o
        |-> ##[1:80] !txd_o)
        else $error("start bit missing after buffer write");
    frame_stop_a: assert property (fr_r == 10'd336 |-> txd_o)
        else $error("stop bit not high");
endmodule

bind unb_uart unb_uart_chk #(.ADDR_W(ADDR_W)) unb_uart_chk_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .t1_ovf(t1_ovf), .rxd_oe_n(rxd_oe_n), .txd_o(txd_o));
